// ===== src/cblc_pkg.sv
`default_nettype none
package cblc_pkg;
   localparam int unsigned CLK_HZ          = 25_000_000;
   localparam int unsigned SHORT_DELAY_US  = 8000;
   localparam int unsigned SHORT_DELAY_CYC = SHORT_DELAY_US * (CLK_HZ / 1_000_000);
   localparam int unsigned SHORT_CNT_W     = 18;
   localparam int unsigned FOLD_TICK_US    = 100;
   localparam int unsigned FOLD_TICK_CYC   = FOLD_TICK_US * (CLK_HZ / 1_000_000);
   localparam int unsigned FOLD_CNT_W      = 12;

   // millivolt and milliamp figures
   localparam logic [10:0] REF_FULL_MV     = 11'h4b0;
   localparam logic [10:0] REF_STEP_MV     = 11'h04b;
   localparam logic [10:0] REF_FLOOR_MV    = 11'h058;
   localparam logic [12:0] SYSTEM_OUTPUT_NODE_TARGET_MV  = 13'h10fe;
   localparam logic [12:0] BOOST_INPUT_SUPPLY_NODE_MV   = 13'h1388;
   localparam logic [10:0] BOOST_ILIM_MA   = 11'h578;

   // register byte addresses
   localparam logic [4:0]  ADDR_CTRL       = 5'h00;
   localparam logic [4:0]  ADDR_USB_LIM    = 5'h04;
   localparam logic [4:0]  ADDR_ADP_LIM    = 5'h08;
   localparam logic [4:0]  ADDR_STATUS     = 5'h0c;
   localparam logic [4:0]  ADDR_REF        = 5'h10;
   localparam logic [4:0]  IDX_IRQ         = 5'h06;
   localparam logic [4:0]  ADDR_IRQ        = 5'(IDX_IRQ * 4);

   // control register fields
   localparam int unsigned CTL_CHG_LSB     = 0;
   localparam int unsigned CTL_UVDIS       = 4;
   localparam int unsigned CTL_BREQ        = 5;
   localparam int unsigned CTL_INHIBIT     = 6;
   localparam int unsigned CTL_PRIO        = 7;
   localparam logic [7:0]  CTRL_RST        = 8'h0f;
   localparam int unsigned IRQ_EN_BIT      = 0;
   localparam int unsigned IRQ_PEND_BIT    = 1;
   localparam logic [4:0]  ILIM_DEFAULT    = 5'h01;

   localparam int unsigned PIN_W           = 9;

   typedef struct packed {
      logic usb_good;
      logic adp_good;
      logic batt_below_fold;
      logic batt_below_low;
      logic id_low;
      logic boost_short;
      logic system_output_node_low;
      logic at_ilim;
      logic input_supply_node_uv;
   } cblc_pins_type;

   typedef enum logic [1:0] {BST_OFF, BST_RUN, BST_FAULT} cblc_boost_type;
endpackage
`default_nettype wire

// ===== src/cblc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cblc_sync (
   input  wire logic                    i_clk,
   input  wire logic                    i_rst_n,
   input  wire cblc_pkg::cblc_pins_type i_d,
   output var cblc_pkg::cblc_pins_type  o_q
);
   import cblc_pkg::*;

   logic [PIN_W-1:0] s1;
   logic [PIN_W-1:0] s2;
   logic [PIN_W-1:0] s3;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= i_d;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // a bit moves only once the second and third stage agree
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_q <= '0;
      end else begin
         o_q <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & o_q);
      end
   end
endmodule
`default_nettype wire

// ===== src/cblc_top.sv
// Notes on behaviour
// (R01) full scale 1.200 is default; 4-bit setting picks fifteen references, 6.25% apart
// (R02) below 3.25V battery the reference ramps down to a floor reached below 2.8V
// (R03) system output target is a fixed 4.35V, not adjustable
// (R04) deeply discharged battery: hold the system output near 3.5V
// (R05) separate 5-bit limit per input; the active input's limit applies
// (R06) USB power removed: USB limit returns to the 100mA default
// (R07) adapter limit returns to default only when both inputs lose power
// (R08) load plus charge at input limit: cut charge just enough for the load
// (R09) throttle near 4.3V input unless software sets the disable bit
// (R10) boost runs the regulator in reverse, lifting the USB input to 5V
// (R11) boost starts from a grounded ID pin or the software request command
// (R12) boost stays off with power on either input or battery below 2.8V
// (R13) boost feeds only the USB input and ignores the priority bit
// (R14) boost gives at least 500mA, limits near 1.4A, lets the bus sag
// (R15) boost short circuit: shut down after about 8ms, set the fault flag
// (R16) ID pin watched always; flag true while the pin is grounded
// (R17) when enabled, each ID status change raises an interrupt request
// (R18) inhibit bit blocks ID autostart but not ID monitoring or reporting
// (R19) request command starts boost regardless of ID status and inhibit bit
// (R20) ID counts as grounded only below about 24k
// (R21) full write to index 6 clears pending interrupts; reading does not; here any write with byte 0 enabled clears them
// (R22) both inputs valid: adapter by default, USB when the priority bit is set
// (R23) short must persist the whole delay, counted on the device clock
//
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cblc_top #(
   parameter int unsigned SHORT_DELAY_CYCLES = cblc_pkg::SHORT_DELAY_CYC
) (
   input  wire logic                    i_clk,
   input  wire logic                    i_rst_n,
   input  wire logic [4:0]              i_avs_address,
   input  wire logic                    i_avs_read,
   input  wire logic                    i_avs_write,
   input  wire logic [31:0]             i_avs_writedata,
   input  wire logic [3:0]              i_avs_byteenable,
   output logic [31:0]                  o_avs_readdata,
   output logic                         o_avs_waitrequest,
   input  wire cblc_pkg::cblc_pins_type i_pins,
   output logic [10:0]                  o_charge_ref_mv,
   output logic [12:0]                  o_system_output_node_target_mv,
   output logic                         o_system_output_node_min_servo,
   output logic                         o_charge_reduce,
   output logic                         o_uv_limit_active,
   output logic                         o_use_usb,
   output logic                         o_use_adapter,
   output logic [4:0]                   o_input_limit_code,
   output logic                         o_boost_enable,
   output logic [12:0]                  o_boost_input_supply_node_mv,
   output logic [10:0]                  o_boost_ilim_ma,
   output logic                         o_irq
);
   import cblc_pkg::*;

   logic                   rst_meta;
   logic                   rst_n;
   cblc_pins_type          pin;
   logic [7:0]             ctrl;
   logic [4:0]             usb_lim;
   logic [4:0]             adp_lim;
   logic                   irq_en;
   logic                   usb_prev;
   logic                   any_prev;
   logic                   id_prev;
   logic [10:0]            fold_ceil;
   logic [FOLD_CNT_W-1:0]  fold_cnt;
   logic                   fold_tick;
   logic [SHORT_CNT_W-1:0] short_cnt;
   logic                   short_done;
   cblc_boost_type         state;
   cblc_boost_type         next_state;
   logic                   boost_fault_flag;
   logic [7:0]             rd_mux;
   logic [10:0]            charge_current_program_pin_mv;
   logic                   req;
   logic                   wr_fire;
   logic                   usb_fall;
   logic                   any_fall;
   logic                   id_change;
   logic                   boost_block;
   logic                   boost_start;
   logic                   boost_on;

   default clocking dclk @(posedge i_clk); endclocking
   default disable iff (!rst_n);
   function automatic logic [10:0] ref_mv(input logic [3:0] code);
      return REF_FULL_MV - 11'(REF_STEP_MV * (4'hf - ((code == 4'h0) ? 4'h1 : code)));
   endfunction

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   cblc_sync u_sync (
      .i_clk   (i_clk),
      .i_rst_n (rst_n),
      .i_d     (i_pins),
      .o_q     (pin)
   );

   // bus slave: one wait cycle, then a single cycle with waitrequest low
   assign req     = i_avs_read | i_avs_write;
   assign wr_fire = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_avs_waitrequest <= 1'b1;
      end else begin
         o_avs_waitrequest <= ~(req & o_avs_waitrequest);
      end
   end

   always_comb begin
      rd_mux = 8'h00;
      if (i_avs_address == ADDR_CTRL) begin
         rd_mux = ctrl;
      end else if (i_avs_address == ADDR_USB_LIM) begin
         rd_mux = {3'h0, usb_lim};
      end else if (i_avs_address == ADDR_ADP_LIM) begin
         rd_mux = {3'h0, adp_lim};
      end else if (i_avs_address == ADDR_STATUS) begin
         rd_mux = {o_use_adapter, o_use_usb, pin.adp_good, pin.usb_good,
                   pin.batt_below_low, boost_fault_flag, boost_on, pin.id_low}; // [R16] [R18] [R20]
      end else if (i_avs_address == ADDR_REF) begin
         rd_mux = o_charge_ref_mv[10:3];
      end else if (i_avs_address == ADDR_IRQ) begin
         rd_mux = {6'h00, o_irq, irq_en};
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_avs_readdata <= 32'h0000_0000;
      end else if (i_avs_read && o_avs_waitrequest) begin
         o_avs_readdata <= {24'h00_0000, rd_mux};
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= CTRL_RST; // [R01]
      end else if (wr_fire && i_avs_address == ADDR_CTRL) begin
         ctrl <= i_avs_writedata[7:0];
      end
   end

   // input limits: hardware default wins over a write in the same cycle
   assign usb_fall = usb_prev & ~pin.usb_good;
   assign any_fall = any_prev & ~(pin.usb_good | pin.adp_good);

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         usb_prev <= 1'b0;
         any_prev <= 1'b0;
         id_prev  <= 1'b0;
      end else begin
         usb_prev <= pin.usb_good;
         any_prev <= pin.usb_good | pin.adp_good;
         id_prev  <= pin.id_low;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         usb_lim <= ILIM_DEFAULT;
      end else if (usb_fall) begin
         usb_lim <= ILIM_DEFAULT; // [R06]
      end else if (wr_fire && i_avs_address == ADDR_USB_LIM) begin
         usb_lim <= i_avs_writedata[4:0]; // [R05]
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         adp_lim <= ILIM_DEFAULT;
      end else if (any_fall) begin
         adp_lim <= ILIM_DEFAULT; // [R07]
      end else if (wr_fire && i_avs_address == ADDR_ADP_LIM) begin
         adp_lim <= i_avs_writedata[4:0]; // [R05]
      end
   end

   // input selection; boost owns the USB input and bypasses priority
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_use_usb          <= 1'b0;
         o_use_adapter      <= 1'b0;
         o_input_limit_code <= ILIM_DEFAULT;
      end else if (boost_on) begin
         o_use_usb          <= 1'b0; // [R13]
         o_use_adapter      <= 1'b0;
         o_input_limit_code <= usb_lim;
      end else if (pin.usb_good && pin.adp_good) begin
         o_use_usb          <= ctrl[CTL_PRIO]; // [R22]
         o_use_adapter      <= ~ctrl[CTL_PRIO];
         o_input_limit_code <= ctrl[CTL_PRIO] ? usb_lim : adp_lim; // [R05]
      end else begin
         o_use_usb          <= pin.usb_good;
         o_use_adapter      <= pin.adp_good;
         o_input_limit_code <= pin.usb_good ? usb_lim : adp_lim; // [R05]
      end
   end

   // low battery foldback of the charge reference
   assign fold_tick = (fold_cnt == FOLD_CNT_W'(FOLD_TICK_CYC - 1));
   assign charge_current_program_pin_mv   = ref_mv(ctrl[CTL_CHG_LSB +: 4]); // [R01]

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         fold_cnt <= '0;
      end else begin
         fold_cnt <= fold_tick ? '0 : fold_cnt + 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         fold_ceil <= REF_FULL_MV;
      end else if (pin.batt_below_low) begin
         fold_ceil <= REF_FLOOR_MV; // [R02]
      end else if (fold_tick && pin.batt_below_fold) begin
         fold_ceil <= (fold_ceil > REF_FLOOR_MV + REF_STEP_MV) ? fold_ceil - REF_STEP_MV : REF_FLOOR_MV; // [R02]
      end else if (fold_tick) begin
         fold_ceil <= (fold_ceil < REF_FULL_MV - REF_STEP_MV) ? fold_ceil + REF_STEP_MV : REF_FULL_MV;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_charge_ref_mv   <= REF_FULL_MV;
         o_system_output_node_target_mv  <= SYSTEM_OUTPUT_NODE_TARGET_MV;
         o_system_output_node_min_servo  <= 1'b0;
         o_charge_reduce   <= 1'b0;
         o_uv_limit_active <= 1'b0;
         o_boost_input_supply_node_mv   <= BOOST_INPUT_SUPPLY_NODE_MV;
         o_boost_ilim_ma   <= BOOST_ILIM_MA;
      end else begin
         o_charge_ref_mv   <= (charge_current_program_pin_mv < fold_ceil) ? charge_current_program_pin_mv : fold_ceil; // [R01] [R02]
         o_system_output_node_target_mv  <= SYSTEM_OUTPUT_NODE_TARGET_MV; // [R03]
         o_system_output_node_min_servo  <= pin.batt_below_fold & pin.system_output_node_low; // [R04]
         o_charge_reduce   <= pin.at_ilim & ~boost_on; // [R08]
         o_uv_limit_active <= pin.input_supply_node_uv & ~ctrl[CTL_UVDIS] & ~boost_on; // [R09]
         o_boost_input_supply_node_mv   <= BOOST_INPUT_SUPPLY_NODE_MV; // [R10]
         o_boost_ilim_ma   <= BOOST_ILIM_MA; // [R14]
      end
   end

   // boost control
   assign boost_block = pin.usb_good | pin.adp_good | pin.batt_below_low; // [R12]
   assign boost_start = (pin.id_low & ~ctrl[CTL_INHIBIT]) | ctrl[CTL_BREQ]; // [R11] [R18] [R19]
   assign boost_on    = (state == BST_RUN);
   assign short_done  = pin.boost_short && short_cnt == SHORT_CNT_W'(SHORT_DELAY_CYCLES - 1);

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         short_cnt <= '0;
      end else if (boost_on && pin.boost_short && !short_done) begin
         short_cnt <= short_cnt + 1'b1; // [R23]
      end else begin
         short_cnt <= '0; // [R23]
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         BST_OFF: begin
            if (boost_start && !boost_block) begin
               next_state = BST_RUN; // [R11]
            end
         end
         BST_RUN: begin
            if (!boost_start || boost_block) begin
               next_state = BST_OFF; // [R12]
            end else if (short_done) begin
               next_state = BST_FAULT; // [R15]
            end
         end
         BST_FAULT: begin
            if (!boost_start) begin
               next_state = BST_OFF;
            end
         end
         default: begin
            next_state = BST_OFF;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         state          <= BST_OFF;
         o_boost_enable <= 1'b0;
      end else begin
         state          <= next_state;
         o_boost_enable <= (next_state == BST_RUN); // [R10]
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         boost_fault_flag <= 1'b0;
      end else if (state == BST_RUN && next_state == BST_FAULT) begin
         boost_fault_flag <= 1'b1; // [R15]
      end else if (state == BST_OFF && next_state == BST_RUN) begin
         boost_fault_flag <= 1'b0;
      end
   end

   // ID change interrupt; a change in the clearing cycle keeps it pending
   assign id_change = pin.id_low ^ id_prev;

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_en <= 1'b0;
      end else if (wr_fire && i_avs_address == ADDR_IRQ) begin
         irq_en <= i_avs_writedata[IRQ_EN_BIT];
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_irq <= 1'b0;
      end else if (irq_en && id_change) begin
         o_irq <= 1'b1; // [R17]
      end else if (wr_fire && i_avs_address == ADDR_IRQ) begin
         o_irq <= 1'b0; // [R21]
      end
   end

   a_boost_blocked: assert property (state == BST_RUN && boost_block // [R12]
      |=> state == BST_OFF && !o_boost_enable) else $error("boost kept running while blocked");
   a_short_count_clear: assert property (boost_on && !pin.boost_short // [R23]
      |=> short_cnt == '0) else $error("short counter not cleared by a gap");
   a_fault_at_delay: assert property (boost_on && short_done && boost_start && !boost_block // [R15]
      |=> state == BST_FAULT ##0 boost_fault_flag) else $error("no shutdown after full short delay");
   a_fault_needs_run: assert property ($rose(boost_fault_flag) // [R23]
      |-> $past(state) == BST_RUN && $past(short_done)) else $error("fault flag without a full short");
   a_usb_lim_default: assert property (usb_fall // [R06]
      |=> usb_lim == ILIM_DEFAULT) else $error("usb limit not reset on power loss");
   a_adp_lim_kept: assert property ((pin.usb_good || pin.adp_good) // [R07]
      && !(wr_fire && i_avs_address == ADDR_ADP_LIM) |=> $stable(adp_lim)) else $error("adapter limit changed");
   a_irq_on_change: assert property (irq_en && id_change // [R17]
      |=> o_irq) else $error("id change lost");
   a_irq_clear: assert property (wr_fire && i_avs_address == ADDR_IRQ && !(irq_en && id_change) // [R21]
      |=> !o_irq) else $error("interrupt not cleared by write");
   a_prio_select: assert property (pin.usb_good && pin.adp_good && !boost_on // [R22]
      |=> o_use_usb == $past(ctrl[CTL_PRIO]) && o_use_adapter != o_use_usb) else $error("wrong input chosen");
   a_uv_gate: assert property (ctrl[CTL_UVDIS] // [R09]
      |=> !o_uv_limit_active) else $error("undervoltage limit active while disabled");
   a_charge_floor: assert property (pin.batt_below_low [*2] // [R02]
      |=> o_charge_ref_mv <= REF_FLOOR_MV) else $error("charge reference above floor at low battery");
   a_inhibit_auto: assert property (state == BST_OFF && ctrl[CTL_INHIBIT] && !ctrl[CTL_BREQ] // [R18]
      |=> state == BST_OFF) else $error("autostart despite inhibit");
   a_bus_answer: assert property (req && o_avs_waitrequest
      |=> !o_avs_waitrequest ##1 o_avs_waitrequest) else $error("bus answer not one cycle after request");
   c_boost_run: cover property (@(posedge i_clk) disable iff (!rst_n) $rose(boost_on));
   c_boost_fault: cover property (@(posedge i_clk) disable iff (!rst_n) $rose(boost_fault_flag));
   c_irq_raise: cover property (@(posedge i_clk) disable iff (!rst_n) $rose(o_irq));
   c_usb_reset: cover property (@(posedge i_clk) disable iff (!rst_n) usb_fall && usb_lim != ILIM_DEFAULT);
endmodule
`default_nettype wire

// ===== dv/cblc_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module cblc_far_side (
   input  wire logic                    i_usb_on,
   input  wire logic                    i_adp_on,
   input  wire logic [12:0]             i_batt_mv,
   input  wire logic [7:0]              i_id_kohm,
   input  wire logic                    i_short,
   input  wire logic                    i_boost_on,
   input  wire logic [1:0]              i_misc,
   output var cblc_pkg::cblc_pins_type  o_pins
);
   import cblc_pkg::*;
   always_comb begin
      o_pins.usb_good        = i_usb_on;
      o_pins.adp_good        = i_adp_on;
      o_pins.batt_below_fold = i_batt_mv < 13'hcb2;
      o_pins.batt_below_low  = i_batt_mv < 13'haf0;
      o_pins.id_low          = i_id_kohm < 8'h18;
      // a short on the bus is only seen while the boost drives it
      o_pins.boost_short     = i_short & i_boost_on;
      o_pins.system_output_node_low        = i_batt_mv < 13'hdac;
      o_pins.at_ilim         = i_misc[0];
      o_pins.input_supply_node_uv         = i_misc[1] & (i_usb_on | i_adp_on);
   end
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import cblc_pkg::*;
   localparam int unsigned SDC = 20;
   typedef struct packed {logic [3:0] s; logic [10:0] r;} cblc_row_type;
   logic          i_clk, i_rst_n, rd, wr, usb_on, adp_on, shrt;
   logic [4:0]    addr;
   logic [31:0]   wdata, rdata, q;
   logic [3:0]    be;
   logic [12:0]   batt_mv, system_output_node_mv, bvbus;
   logic [7:0]    id_k;
   logic [1:0]    misc;
   logic [10:0]   ref_mv, bilim;
   logic [4:0]    lim;
   logic          wait_n, servo, red, uv, use_u, use_a, boost, irq;
   cblc_pins_type pins;
   int            fail_count, checks, cyc;
   cblc_row_type  rows [5] = '{'{4'hf, 11'h4b0}, '{4'he, 11'h465}, '{4'h8, 11'h2a3},
                               '{4'h1, 11'h096}, '{4'h0, 11'h096}};

   cblc_far_side cblc_far_side_i (.i_usb_on(usb_on), .i_adp_on(adp_on), .i_batt_mv(batt_mv),
      .i_id_kohm(id_k), .i_short(shrt), .i_boost_on(boost), .i_misc(misc), .o_pins(pins));
   cblc_top #(.SHORT_DELAY_CYCLES(SDC)) cblc_top_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
      .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_n), .i_pins(pins),
      .o_charge_ref_mv(ref_mv), .o_system_output_node_target_mv(system_output_node_mv), .o_system_output_node_min_servo(servo),
      .o_charge_reduce(red), .o_uv_limit_active(uv), .o_use_usb(use_u), .o_use_adapter(use_a),
      .o_input_limit_code(lim), .o_boost_enable(boost), .o_boost_input_supply_node_mv(bvbus),
      .o_boost_ilim_ma(bilim), .o_irq(irq));

   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         complete_run();
      end
   end

   // one bus cycle; request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge i_clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge i_clk);
      end while (wait_n !== 1'b0);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic cmp_port(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cmp_reg(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      cmp_port($sformatf("reg %h", a), e, q);
   endtask

   task automatic settle;
      repeat (8) @(posedge i_clk);
   endtask

   initial begin
      i_rst_n = 1'b0;
      {rd, wr, usb_on, adp_on, shrt, misc, addr, wdata} = '0;
      be = 4'hf;
      batt_mv = 13'he74;
      id_k = 8'h64;
      repeat (10) @(posedge i_clk);
      i_rst_n <= 1'b1;
      settle();
      cmp_reg(ADDR_CTRL, 32'h0f);
      cmp_reg(ADDR_USB_LIM, 32'h01);
      cmp_reg(ADDR_ADP_LIM, 32'h01);
      cmp_reg(5'h14, 32'h0);
      cmp_port("system_output_node", 13'h10fe, system_output_node_mv);
      cmp_port("bvbus", 13'h1388, bvbus);
      cmp_port("bilim", 11'h578, bilim);
      for (int k = 0; k < 5; k++) begin
         bus(1'b1, ADDR_CTRL, {28'h0, rows[k].s});
         settle();
         cmp_port("ref", rows[k].r, ref_mv);
         cmp_reg(ADDR_REF, rows[k].r[10:3]);
      end
      $display("test charge rows done");
      be <= 4'h0;
      bus(1'b1, ADDR_CTRL, 32'h0f);
      be <= 4'hf;
      cmp_reg(ADDR_CTRL, 32'h00);
      bus(1'b1, ADDR_USB_LIM, 32'h0a);
      bus(1'b1, ADDR_ADP_LIM, 32'h15);
      usb_on <= 1'b1;
      settle();
      cmp_port("use_usb", 1'b1, use_u);
      cmp_port("lim", 5'h0a, lim);
      adp_on <= 1'b1;
      misc <= 2'h3;
      settle();
      cmp_port("use_adp", 1'b1, use_a);
      cmp_port("lim", 5'h15, lim);
      cmp_port("reduce", 1'b1, red);
      cmp_port("uv", 1'b1, uv);
      bus(1'b1, ADDR_CTRL, 32'h9f);
      settle();
      cmp_port("use_usb", 1'b1, use_u);
      cmp_port("uv", 1'b0, uv);
      bus(1'b1, ADDR_CTRL, 32'h0f);
      misc <= 2'h0;
      usb_on <= 1'b0;
      settle();
      cmp_reg(ADDR_USB_LIM, 32'h01);
      cmp_reg(ADDR_ADP_LIM, 32'h15);
      adp_on <= 1'b0;
      settle();
      cmp_reg(ADDR_ADP_LIM, 32'h01);
      $display("test inputs done");
      id_k <= 8'h0a;
      settle();
      cmp_port("boost", 1'b1, boost);
      cmp_reg(ADDR_STATUS, 32'h03);
      bus(1'b1, ADDR_CTRL, 32'h4f);
      settle();
      cmp_port("boost", 1'b0, boost);
      cmp_reg(ADDR_STATUS, 32'h01);
      bus(1'b1, ADDR_CTRL, 32'hef);
      settle();
      cmp_port("boost", 1'b1, boost);
      cmp_port("use", 2'b00, {use_u, use_a});
      usb_on <= 1'b1;
      settle();
      cmp_port("boost", 1'b0, boost);
      usb_on <= 1'b0;
      batt_mv <= 13'h960;
      settle();
      cmp_port("boost", 1'b0, boost);
      cmp_port("ref", 11'h058, ref_mv);
      cmp_port("servo", 1'b1, servo);
      batt_mv <= 13'he74;
      id_k <= 8'h64;
      bus(1'b1, ADDR_CTRL, 32'h2f);
      settle();
      cmp_port("boost", 1'b1, boost);
      shrt <= 1'b1;
      repeat (SDC - 5) @(posedge i_clk);
      shrt <= 1'b0;
      settle();
      cmp_port("boost", 1'b1, boost);
      shrt <= 1'b1;
      repeat (SDC + 10) @(posedge i_clk);
      shrt <= 1'b0;
      cmp_port("boost", 1'b0, boost);
      cmp_reg(ADDR_STATUS, 32'h04);
      bus(1'b1, ADDR_CTRL, 32'h0f);
      bus(1'b1, ADDR_CTRL, 32'h2f);
      settle();
      cmp_reg(ADDR_STATUS, 32'h02);
      $display("test boost done");
      bus(1'b1, ADDR_CTRL, 32'h4f);
      bus(1'b1, ADDR_IRQ, 32'h01);
      id_k <= 8'h0a;
      settle();
      cmp_reg(ADDR_IRQ, 32'h03);
      cmp_port("irq", 1'b1, irq);
      bus(1'b1, ADDR_IRQ, 32'h01);
      settle();
      cmp_port("irq", 1'b0, irq);
      id_k <= 8'h64;
      settle();
      cmp_port("irq", 1'b1, irq);
      bus(1'b1, ADDR_IRQ, 32'h00);
      id_k <= 8'h0a;
      settle();
      cmp_port("irq", 1'b0, irq);
      $display("test irq done");
      bus(1'b1, ADDR_USB_LIM, 32'h0a);
      batt_mv <= 13'h960;
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      batt_mv <= 13'he74;
      settle();
      cmp_reg(ADDR_CTRL, 32'h0f);
      cmp_reg(ADDR_USB_LIM, 32'h01);
      cmp_port("ref", 11'h4b0, ref_mv);
      $display("test reset done");
      complete_run();
   end
endmodule
`default_nettype wire
